// file: pkg/tsn_pkg.sv
/*
  shared constants and carriers of the timestamp and notice block.
  assumes a 20 MHz single clock and an APB register bus with byte addresses.
*/
package tsn_pkg;

  // clock and tick timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000;
  localparam logic [4:0] TICK_DIV = 5'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [31:0] TICKS_PER_SECOND = 32'h000f4240;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HELD_LO = 8'h04;
  localparam logic [7:0] ADDR_HELD_HI = 8'h08;
  localparam logic [7:0] ADDR_TICKS = 8'h0c;
  localparam logic [7:0] ADDR_SELECT = 8'h10;
  localparam logic [7:0] ADDR_NOTIFY = 8'h14;
  localparam logic [7:0] ADDR_ENABLED = 8'h18;
  localparam logic [7:0] ADDR_PENDING = 8'h1c;

  // control register fields
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_TRIG_FRAME_BIT = 2;

  // notice enable setting codes
  localparam logic [1:0] SET_OFF = 2'h0;
  localparam logic [1:0] SET_ON = 2'h1;
  localparam logic [1:0] SET_LEGACY = 2'h2;

  // notice type codes, also the bit index in enable and pending masks
  localparam int NT_FRAME_FINISH = 0;
  localparam int NT_FRAME_BEGIN = 1;
  localparam int NT_ACCEPTED_FRAME_TRIG = 2;
  localparam int NT_REFUSED_FRAME_TRIG = 3;
  localparam int NT_DROPPED_PICTURE = 4;
  localparam int NT_REFUSED_ROW_TRIG = 5;
  localparam int NT_INPUT_RISE_FIRST = 6;
  localparam int NT_CAPTURE_BEGIN = 12;
  localparam int NT_CAPTURE_FINISH = 13;
  localparam int NT_SPILL = 14;
  localparam int NUM_TYPES = 15;
  localparam int NUM_INPUTS = 3;

  // reset values
  localparam logic [63:0] COUNT_RESET = 64'h0;
  localparam logic [3:0] SELECT_RESET = 4'h0;

  // one outgoing notice message
  typedef struct packed {
    logic valid;
    logic legacy;
    logic [3:0] code;
    logic [63:0] stamp;
  } tsn_notice_t;

  // whole state of the block
  typedef struct packed {
    logic [63:0] cnt;
    logic [63:0] held;
    logic [4:0] div;
    logic [3:0] sel;
    logic trig_frame;
    logic [NUM_TYPES-1:0][1:0] setting;
    logic [NUM_TYPES-1:0] pend;
    logic [NUM_INPUTS-1:0] sync1;
    logic [NUM_INPUTS-1:0] sync2;
    logic [NUM_INPUTS-1:0] prev;
    logic [31:0] rdata;
    logic frame_go;
    logic row_go;
    tsn_notice_t msg;
  } tsn_state_t;

endpackage : tsn_pkg

// file: verilog/tsn_timestamp_notifier.sv
/*
  64-bit timestamp counter with capture and clear, plus a notice unit
  that queues one message per notice type and hands them out by priority.
  assumes an APB master on i_ref_clk, same-clock event strobes and three
  asynchronous input pins.
*/
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
module tsn_timestamp_notifier (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_frame_begin,
  input wire logic i_frame_end,
  input wire logic i_frame_trig,
  input wire logic i_frame_trig_blocked,
  input wire logic i_row_trig,
  input wire logic i_row_trig_blocked,
  input wire logic i_picture_dropped,
  input wire logic i_capture_begin,
  input wire logic i_capture_finish,
  input wire logic [tsn_pkg::NUM_INPUTS-1:0] i_input_lines,
  output logic o_frame_trig_go,
  output logic o_row_trig_go,
  output tsn_pkg::tsn_notice_t o_notice,
  input wire logic i_notice_ready
);

  tsn_pkg::tsn_state_t q;
  tsn_pkg::tsn_state_t n;
  logic tick;
  logic wr_access;
  logic rd_setup;
  logic addr_ok;
  logic cap_cmd;
  logic clr_cmd;
  logic wr_notify;
  logic slot_free;
  logic spill;
  logic [3:0] grant_idx;
  logic [tsn_pkg::NUM_TYPES-1:0] ev;
  logic [tsn_pkg::NUM_TYPES-1:0] en;
  logic [31:0] rd_mux;

  // bus decode
  assign wr_access = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable;
  assign addr_ok = (i_paddr == tsn_pkg::ADDR_CTRL) || (i_paddr == tsn_pkg::ADDR_HELD_LO) ||
                   (i_paddr == tsn_pkg::ADDR_HELD_HI) || (i_paddr == tsn_pkg::ADDR_TICKS) ||
                   (i_paddr == tsn_pkg::ADDR_SELECT) || (i_paddr == tsn_pkg::ADDR_NOTIFY) ||
                   (i_paddr == tsn_pkg::ADDR_ENABLED) || (i_paddr == tsn_pkg::ADDR_PENDING);
  assign cap_cmd = wr_access && (i_paddr == tsn_pkg::ADDR_CTRL) &&
                   i_pwdata[tsn_pkg::CTRL_CAPTURE_BIT];
  assign clr_cmd = wr_access && (i_paddr == tsn_pkg::ADDR_CTRL) &&
                   i_pwdata[tsn_pkg::CTRL_CLEAR_BIT];
  assign wr_notify = wr_access && (i_paddr == tsn_pkg::ADDR_NOTIFY);

  // zero-wait slave, error on unmapped offset
  assign o_pready = i_psel & i_penable;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;
  assign o_prdata = q.rdata;
  assign o_frame_trig_go = q.frame_go;
  assign o_row_trig_go = q.row_go;
  assign o_notice = q.msg;

  assign tick = (q.div == tsn_pkg::TICK_DIV - 5'h1);

  // raw event strobes
  assign ev[tsn_pkg::NT_FRAME_FINISH] = i_frame_end;
  assign ev[tsn_pkg::NT_FRAME_BEGIN] = i_frame_begin;
  assign ev[tsn_pkg::NT_ACCEPTED_FRAME_TRIG] = i_frame_trig & ~i_frame_trig_blocked;
  assign ev[tsn_pkg::NT_REFUSED_FRAME_TRIG] = i_frame_trig & i_frame_trig_blocked;
  assign ev[tsn_pkg::NT_DROPPED_PICTURE] = i_picture_dropped;
  assign ev[tsn_pkg::NT_REFUSED_ROW_TRIG] = i_row_trig & i_row_trig_blocked;
  assign ev[tsn_pkg::NT_CAPTURE_BEGIN] = i_capture_begin;
  assign ev[tsn_pkg::NT_CAPTURE_FINISH] = i_capture_finish;
  assign ev[tsn_pkg::NT_SPILL] = 1'b0; // raised only by overflow

  // per-input edge detect on synchronised pins
  for (genvar g = 0; g < tsn_pkg::NUM_INPUTS; g++) begin : g_line
    assign ev[tsn_pkg::NT_INPUT_RISE_FIRST + 2 * g] = q.sync2[g] & ~q.prev[g];
    assign ev[tsn_pkg::NT_INPUT_RISE_FIRST + 2 * g + 1] = ~q.sync2[g] & q.prev[g];
  end

  // enable mask from settings, lowest pending type wins the slot
  always_comb begin
    grant_idx = 4'h0;
    for (int k = 0; k < tsn_pkg::NUM_TYPES; k++) begin
      en[k] = (q.setting[k] != tsn_pkg::SET_OFF);
    end
    for (int k = tsn_pkg::NUM_TYPES - 1; k >= 0; k--) begin
      if (q.pend[k]) begin
        grant_idx = 4'(k);
      end
    end
  end

  assign slot_free = ~q.msg.valid | i_notice_ready;

  // read data for the register addressed in the setup cycle
  always_comb begin
    case (i_paddr)
      tsn_pkg::ADDR_CTRL: rd_mux = {29'h0, q.trig_frame, 2'h0};
      // held value read-only, 64 bits in two words
      tsn_pkg::ADDR_HELD_LO: rd_mux = q.held[31:0];
      tsn_pkg::ADDR_HELD_HI: rd_mux = q.held[63:32];
      tsn_pkg::ADDR_TICKS: rd_mux = tsn_pkg::TICKS_PER_SECOND;
      tsn_pkg::ADDR_SELECT: rd_mux = {28'h0, q.sel};
      tsn_pkg::ADDR_NOTIFY: begin
        rd_mux = (q.sel < 4'(tsn_pkg::NUM_TYPES)) ? {30'h0, q.setting[q.sel]} : 32'h0;
      end
      tsn_pkg::ADDR_ENABLED: rd_mux = {17'h0, en};
      tsn_pkg::ADDR_PENDING: rd_mux = {17'h0, q.pend};
      default: rd_mux = 32'h0;
    endcase
  end

  // next state
  always_comb begin
    n = q;
    spill = 1'b0;
    // clear restarts the divider so zero lasts a whole tick
    n.div = (tick || clr_cmd) ? 5'h0 : q.div + 5'h1;
    if (clr_cmd) begin
      n.cnt = tsn_pkg::COUNT_RESET;
    end else if (tick) begin
      n.cnt = q.cnt + 64'h1;
    end
    if (cap_cmd) begin
      n.held = q.cnt;
    end else if (q.trig_frame && i_frame_begin) begin
      n.held = q.cnt;
    end
    if (wr_access && (i_paddr == tsn_pkg::ADDR_CTRL)) begin
      n.trig_frame = i_pwdata[tsn_pkg::CTRL_TRIG_FRAME_BIT];
    end
    if (wr_access && (i_paddr == tsn_pkg::ADDR_SELECT)) begin
      n.sel = i_pwdata[3:0];
    end
    // enable applies to selected type only
    if (wr_notify && (q.sel < 4'(tsn_pkg::NUM_TYPES))) begin
      n.setting[q.sel] = (i_pwdata[1:0] == 2'h3) ? tsn_pkg::SET_OFF : i_pwdata[1:0];
    end
    if (rd_setup) begin
      n.rdata = rd_mux;
    end
    // pin synchronisers
    n.sync1 = i_input_lines;
    n.sync2 = q.sync1;
    n.prev = q.sync2;
    n.frame_go = i_frame_trig & ~i_frame_trig_blocked;
    n.row_go = i_row_trig & ~i_row_trig_blocked;
    // hand the next message out
    if (slot_free) begin
      n.msg.valid = |q.pend;
      if (|q.pend) begin
        n.msg.legacy = (q.setting[grant_idx] == tsn_pkg::SET_LEGACY);
        n.msg.code = grant_idx;
        n.msg.stamp = q.cnt;
        n.pend[grant_idx] = 1'b0;
      end
    end
    for (int k = 0; k < tsn_pkg::NUM_TYPES; k++) begin
      if (ev[k] && en[k]) begin
        if (n.pend[k]) begin
          spill = 1'b1;
        end
        n.pend[k] = 1'b1;
      end
    end
    // overflow turns all off and queues spill
    if (spill) begin
      n.setting = '0;
      n.pend[tsn_pkg::NT_SPILL] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      q <= '0;
      q.cnt <= tsn_pkg::COUNT_RESET;
      q.held <= tsn_pkg::COUNT_RESET;
      q.sel <= tsn_pkg::SELECT_RESET;
    end else begin
      q <= n;
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_cap_cmd;
    cap_cmd;
  endsequence
  sequence s_read_ticks;
    (rd_setup && !i_pwrite && (i_paddr == tsn_pkg::ADDR_TICKS)) ##1 (i_psel && i_penable);
  endsequence

  property p_capture_cmd;
    s_cap_cmd |=> (q.held == $past(q.cnt)) && (q.cnt != 64'h0 || $past(q.cnt) == 64'h0 ||
      $past(clr_cmd));
  endproperty
  a_capture_cmd: assert property (p_capture_cmd) else $error("capture missed counter");

  property p_tick_count;
    tick && !clr_cmd |=> q.cnt == $past(q.cnt) + 64'h1;
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("counter did not step");

  property p_tick_spacing;
    tick |=> (!tick)[*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");

  property p_ticks_read;
    s_read_ticks |-> o_prdata == tsn_pkg::TICKS_PER_SECOND;
  endproperty
  a_ticks_read: assert property (p_ticks_read) else $error("wrong tick rate read");

  property p_frame_capture;
    q.trig_frame && i_frame_begin && !cap_cmd |=> q.held == $past(q.cnt);
  endproperty
  a_frame_capture: assert property (p_frame_capture) else $error("frame capture missed");

  property p_clear;
    clr_cmd |=> q.cnt == 64'h0 ##[20:21] q.cnt == 64'h1;
  endproperty
  a_clear: assert property (p_clear) else $error("clear or resume wrong");

  property p_select_write;
    wr_notify && !spill && (q.sel == 4'h0) && (i_pwdata[1:0] != 2'h3) |=>
      q.setting[0] == $past(i_pwdata[1:0]) && q.setting[1] == $past(q.setting[1]);
  endproperty
  a_select_write: assert property (p_select_write) else $error("enable went astray");

  property p_frame_finish;
    ev[tsn_pkg::NT_FRAME_FINISH] && en[tsn_pkg::NT_FRAME_FINISH] |=>
      q.pend[tsn_pkg::NT_FRAME_FINISH];
  endproperty
  a_frame_finish: assert property (p_frame_finish) else $error("frame finish lost");

  property p_rise_first;
    ev[tsn_pkg::NT_INPUT_RISE_FIRST] && en[tsn_pkg::NT_INPUT_RISE_FIRST] |=>
      q.pend[tsn_pkg::NT_INPUT_RISE_FIRST];
  endproperty
  a_rise_first: assert property (p_rise_first) else $error("rising edge lost");

  property p_frame_reject;
    i_frame_trig && i_frame_trig_blocked |=> !o_frame_trig_go;
  endproperty
  a_frame_reject: assert property (p_frame_reject) else $error("blocked trigger passed");

  property p_off_silent;
    !en[tsn_pkg::NT_FRAME_FINISH] && !q.pend[tsn_pkg::NT_FRAME_FINISH] |=>
      !q.pend[tsn_pkg::NT_FRAME_FINISH];
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("disabled type queued");

  property p_spill;
    spill |=> (en == '0) && q.pend[tsn_pkg::NT_SPILL];
  endproperty
  a_spill: assert property (p_spill) else $error("overflow not handled");

  sequence s_msg_waiting;
    q.msg.valid && !i_notice_ready;
  endsequence

  property p_frame_begin;
    ev[tsn_pkg::NT_FRAME_BEGIN] && en[tsn_pkg::NT_FRAME_BEGIN] |=>
      q.pend[tsn_pkg::NT_FRAME_BEGIN];
  endproperty
  a_frame_begin: assert property (p_frame_begin) else $error("frame begin lost");

  property p_accept_go;
    i_frame_trig && !i_frame_trig_blocked |=> o_frame_trig_go;
  endproperty
  a_accept_go: assert property (p_accept_go) else $error("accepted trigger lost");

  property p_dropped;
    ev[tsn_pkg::NT_DROPPED_PICTURE] && en[tsn_pkg::NT_DROPPED_PICTURE] |=>
      q.pend[tsn_pkg::NT_DROPPED_PICTURE];
  endproperty
  a_dropped: assert property (p_dropped) else $error("dropped picture lost");

  property p_row_reject;
    i_row_trig && i_row_trig_blocked |=> !o_row_trig_go;
  endproperty
  a_row_reject: assert property (p_row_reject) else $error("row trigger passed");

  property p_fall_first;
    ev[tsn_pkg::NT_INPUT_RISE_FIRST + 1] && en[tsn_pkg::NT_INPUT_RISE_FIRST + 1] |=>
      q.pend[tsn_pkg::NT_INPUT_RISE_FIRST + 1];
  endproperty
  a_fall_first: assert property (p_fall_first) else $error("falling edge lost");

  property p_capture_begin;
    ev[tsn_pkg::NT_CAPTURE_BEGIN] && en[tsn_pkg::NT_CAPTURE_BEGIN] |=>
      q.pend[tsn_pkg::NT_CAPTURE_BEGIN];
  endproperty
  a_capture_begin: assert property (p_capture_begin) else $error("capture begin lost");

  property p_capture_finish;
    ev[tsn_pkg::NT_CAPTURE_FINISH] && en[tsn_pkg::NT_CAPTURE_FINISH] |=>
      q.pend[tsn_pkg::NT_CAPTURE_FINISH];
  endproperty
  a_capture_finish: assert property (p_capture_finish) else $error("capture end lost");

  property p_msg_hold;
    s_msg_waiting |=> q.msg.valid && $stable(q.msg.code) && $stable(q.msg.stamp);
  endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("message not held");

  property p_reset;
    disable iff (1'b0) i_reset |=> (q.cnt == 64'h0) && (q.held == 64'h0) && (en == '0);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : tsn_timestamp_notifier

// file: bench/tsn_host_model.sv
/*
  host side model: takes notice messages, answers promptly or stalls.
  assumes the notice port of the timestamp block, same clock.
*/
`timescale 1ns/1ns
module tsn_host_model (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_stall,
  input wire tsn_pkg::tsn_notice_t i_notice,
  output logic o_ready,
  output logic [7:0] o_count,
  output tsn_pkg::tsn_notice_t o_last
);
  // accept on valid and ready; stall holds ready low
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_ready <= 1'b0;
      o_count <= 8'h00;
      o_last <= '0;
    end else begin
      o_ready <= !i_stall;
      if (i_notice.valid && o_ready) begin
        o_count <= o_count + 8'h01;
        o_last <= i_notice;
      end
    end
  end
endmodule : tsn_host_model

// file: bench/tb_top.sv
/*
  self-checking bench of the timestamp and notice block.
  assumes zero wait APB and the host model on the notice port.
*/
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, serr, stall = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prdata, rdat;
  logic fe = 1'b0, fb = 1'b0, ft = 1'b0, ftb = 1'b0, rt = 1'b0, rtb = 1'b0;
  logic pd = 1'b0, cb = 1'b0, cf = 1'b0, fgo, rgo, ready, rerr;
  logic [2:0] lines = 3'h0;
  logic [7:0] hcnt;
  tsn_pkg::tsn_notice_t notice, last;
  int err_total = 0;
  int cmp_count = 0;
  int fgo_n = 0;
  int rgo_n = 0;

  tsn_timestamp_notifier tsn_timestamp_notifier_i (.i_ref_clk(clk), .i_reset(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(serr), .i_frame_begin(fb),
    .i_frame_end(fe), .i_frame_trig(ft), .i_frame_trig_blocked(ftb), .i_row_trig(rt),
    .i_row_trig_blocked(rtb), .i_picture_dropped(pd), .i_capture_begin(cb),
    .i_capture_finish(cf), .i_input_lines(lines), .o_frame_trig_go(fgo),
    .o_row_trig_go(rgo), .o_notice(notice), .i_notice_ready(ready));
  tsn_host_model tsn_host_model_i (.i_ref_clk(clk), .i_reset(rst), .i_stall(stall),
    .i_notice(notice), .o_ready(ready), .o_count(hcnt), .o_last(last));

  // clock at 20 MHz
  initial begin
    forever #25 clk = ~clk;
  end
  // count trigger go pulses
  always @(posedge clk) begin
    if (fgo) fgo_n <= fgo_n + 1;
    if (rgo) rgo_n <= rgo_n + 1;
  end

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!(pready === 1'b1) && k < 50);
    if (k >= 50) err_total++;
    rdat = prdata;
    rerr = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // one pulse of the strobe behind a notice code, or one edge on the input pin for codes 6 to 11
  task automatic fire(input int c);
    @(posedge clk);
    case (c)
      0: fe <= 1'b1;
      1: fb <= 1'b1;
      2: ft <= 1'b1;
      3: begin
        ft <= 1'b1;
        ftb <= 1'b1;
      end
      4: pd <= 1'b1;
      5: begin
        rt <= 1'b1;
        rtb <= 1'b1;
      end
      12: cb <= 1'b1;
      13: cf <= 1'b1;
      default: lines[(c-6)/2] <= ~c[0];
    endcase
    @(posedge clk);
    {fe, fb, ft, ftb, pd, rt, rtb, cb, cf} <= '0;
  endtask : fire

  task automatic wait_cnt(input logic [7:0] t);
    int k;
    k = 0;
    while (hcnt != t && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk("msg count", hcnt, t);
  endtask : wait_cnt

  task automatic t_reset();
    rd(tsn_pkg::ADDR_ENABLED);
    chk("enabled", rdat, 0);
    wr(tsn_pkg::ADDR_HELD_LO, 32'hffffffff);
    rd(tsn_pkg::ADDR_HELD_LO);
    chk("held lo", rdat, 0);
    rd(8'h20);
    chk("unmapped err", rerr, 1);
    rd(tsn_pkg::ADDR_TICKS);
    chk("ticks", rdat, tsn_pkg::TICKS_PER_SECOND);
  endtask : t_reset

  task automatic t_stamp();
    logic [31:0] a;
    wr(tsn_pkg::ADDR_CTRL, 32'h2);
    wr(tsn_pkg::ADDR_CTRL, 32'h1);
    rd(tsn_pkg::ADDR_HELD_HI);
    chk("held hi", rdat, 0);
    rd(tsn_pkg::ADDR_HELD_LO);
    chk("held lo after clear", rdat, 0);
    wr(tsn_pkg::ADDR_CTRL, 32'h1);
    rd(tsn_pkg::ADDR_HELD_LO);
    a = rdat;
    repeat (396) @(posedge clk);
    wr(tsn_pkg::ADDR_CTRL, 32'h1);
    rd(tsn_pkg::ADDR_HELD_LO);
    chk("ticks in 400", rdat - a, 20);
    wr(tsn_pkg::ADDR_CTRL, 32'h6);
    fire(1);
    rd(tsn_pkg::ADDR_HELD_LO);
    chk("frame held", rdat, 0);
    wr(tsn_pkg::ADDR_CTRL, 32'h0);
  endtask : t_stamp

  task automatic t_types();
    int g0;
    int r0;
    for (int c = 0; c < 14; c++) begin
      wr(tsn_pkg::ADDR_SELECT, c);
      wr(tsn_pkg::ADDR_NOTIFY, c[0] ? tsn_pkg::SET_LEGACY : tsn_pkg::SET_ON);
      rd(tsn_pkg::ADDR_ENABLED);
      chk("enabled", rdat, 64'h1 << c);
      g0 = fgo_n;
      r0 = rgo_n;
      fire(c);
      wait_cnt(hcnt + 8'h01);
      chk("code", last.code, c);
      chk("legacy", last.legacy, c[0]);
      chk("frame go", fgo_n - g0, c == 2);
      chk("row go", rgo_n - r0, 0);
      wr(tsn_pkg::ADDR_NOTIFY, tsn_pkg::SET_OFF);
    end
    fire(0);
    repeat (20) @(posedge clk);
    chk("off count", hcnt, 8'd14);
  endtask : t_types

  task automatic t_spill();
    logic [7:0] n;
    wr(tsn_pkg::ADDR_SELECT, 0);
    wr(tsn_pkg::ADDR_NOTIFY, tsn_pkg::SET_ON);
    n = hcnt;
    stall <= 1'b1;
    repeat (3) fire(0);
    rd(tsn_pkg::ADDR_ENABLED);
    chk("spill off", rdat, 0);
    stall <= 1'b0;
    wait_cnt(n + 8'h03);
    chk("spill code", last.code, tsn_pkg::NT_SPILL);
    chk("spill legacy", last.legacy, 0);
    wr(tsn_pkg::ADDR_SELECT, 1);
    wr(tsn_pkg::ADDR_NOTIFY, tsn_pkg::SET_ON);
    rd(tsn_pkg::ADDR_NOTIFY);
    chk("re-enabled", rdat, tsn_pkg::SET_ON);
    wr(tsn_pkg::ADDR_NOTIFY, 32'h3);
    rd(tsn_pkg::ADDR_NOTIFY);
    chk("setting code 3", rdat, tsn_pkg::SET_OFF);
    wr(tsn_pkg::ADDR_NOTIFY, tsn_pkg::SET_ON);
    wr(tsn_pkg::ADDR_CTRL, 32'h2);
    n = hcnt;
    fire(1);
    wait_cnt(n + 8'h01);
    chk("stamp after clear", last.stamp, 0);
    wr(tsn_pkg::ADDR_NOTIFY, tsn_pkg::SET_OFF);
  endtask : t_spill

  // accepted row trigger gives one go pulse
  task automatic t_row_go();
    int r0;
    r0 = rgo_n;
    @(posedge clk);
    rt <= 1'b1;
    @(posedge clk);
    rt <= 1'b0;
    repeat (3) @(posedge clk);
    chk("row go pulse", rgo_n - r0, 1);
  endtask : t_row_go

  // reset in mid-run after capture and enable
  task automatic t_rerst();
    wr(tsn_pkg::ADDR_SELECT, 2);
    wr(tsn_pkg::ADDR_NOTIFY, tsn_pkg::SET_ON);
    repeat (20) @(posedge clk);
    wr(tsn_pkg::ADDR_CTRL, 32'h1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("notice after reset", notice.valid, 0);
    rd(tsn_pkg::ADDR_HELD_LO);
    chk("held after reset", rdat, 0);
    rd(tsn_pkg::ADDR_ENABLED);
    chk("enabled after reset", rdat, 0);
    rd(tsn_pkg::ADDR_SELECT);
    chk("select after reset", rdat, 0);
  endtask : t_rerst

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_stamp();
    t_types();
    t_row_go();
    t_spill();
    t_rerst();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #3000000;
    err_total++;
    tally_and_finish();
  end
endmodule : tb_top
